// ### dio_monitor.sv
module dio_monitor
   import dio_pkg::*;
(
   input logic core_clk,
   input logic rst,
   input logic [IDX_W-1:0] core_idx,
   input logic core_wr,
   input logic core_wr_val,
   input logic core_en_wr,
   input logic [CORE_N-1:0] core_discrete_out,
   input logic [CORE_N-1:0] core_discrete_oe,
   input logic sw_trigger,
   input logic trigger_fire,
   input logic [SHUNT_N-1:0] shunt_fault,
   input logic [SHUNT_N-1:0] shunt_sink,
   input logic [SHUNT_IDX_W-1:0] shunt_idx,
   input logic shunt_wr,
   input logic shunt_wr_ground
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_reset_off: assert property ($fell(rst) |-> !core_discrete_oe && !shunt_sink)
      else $error("drive at reset");
   chk_wr_drive: assert property (core_wr && core_idx == 4'h4 |=> core_discrete_oe[3] &&
      core_discrete_out[3] == $past(core_wr_val)) else $error("write lost");
   chk_bad_idx: assert property (core_wr && core_idx == 4'h9 |=> $stable(core_discrete_oe))
      else $error("bad index used");
   chk_oe_hold: assert property (!core_wr && !core_en_wr |=> $stable(core_discrete_oe[3]))
      else $error("oe moved");
   chk_sw_fire: assert property (sw_trigger |=> trigger_fire)
      else $error("no fire");
   chk_sink_wr: assert property (shunt_wr && shunt_idx == 5'h01 && !shunt_fault[1] |=>
      shunt_sink[1] == $past(shunt_wr_ground)) else $error("sink write lost");
   chk_fault_off: assert property (shunt_fault[1] [*2] |-> !shunt_sink[1])
      else $error("sink in fault");
   chk_no_rise: assert property (!shunt_wr |=> !$rose(shunt_sink[1]))
      else $error("sink rose");
endmodule : dio_monitor

// ### dio_pins.sv
module dio_pins
   import dio_pkg::*;
(
   input logic [CORE_N-1:0] out,
   input logic [CORE_N-1:0] oe,
   input logic [CORE_N-1:0] ext,
   input logic [SHUNT_N-1:0] sink,
   input logic [SHUNT_N-1:0] load,
   output logic [CORE_N-1:0] pin,
   output logic [SHUNT_N-1:0] spin
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pin = (oe & out) | (~oe & ext);
   assign spin = ~(sink | load); // pull-up, open unless grounded
endmodule : dio_pins

// ### dio_pkg.sv
package dio_pkg;
   localparam int unsigned CORE_N     = 8;
   localparam int unsigned SHUNT_N    = 16;
   localparam int unsigned TRIG_N     = 3;
   localparam int unsigned IDX_W      = 4;
   localparam int unsigned SHUNT_IDX_W = 5;
   localparam logic [IDX_W-1:0] CORE_IDX_FIRST = 4'h1;
   localparam logic [IDX_W-1:0] CORE_IDX_LAST  = 4'h8;
   localparam int unsigned TRIG_BASE  = 0;
   localparam int unsigned SYNC_BASE  = 4;
   localparam logic [CORE_N-1:0]  CORE_OUT_RST  = 8'h00;
   localparam logic [CORE_N-1:0]  CORE_EN_RST   = 8'h00;
   localparam logic [SHUNT_N-1:0] SHUNT_DRV_RST = 16'h0000;
   localparam logic [TRIG_N-1:0]  TRIG_RST      = 3'h0;
endpackage : dio_pkg

// ### discrete_io_trigger_sync.sv
module discrete_io_trigger_sync
   import dio_pkg::*;
(
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   input  wire logic [dio_pkg::CORE_N-1:0]          core_discrete_in,
   output logic      [dio_pkg::CORE_N-1:0]          core_discrete_out,
   output logic      [dio_pkg::CORE_N-1:0]          core_discrete_oe,
   input  wire logic [dio_pkg::IDX_W-1:0]           core_idx,
   input  wire logic                                core_wr,
   input  wire logic                                core_wr_val,
   input  wire logic                                core_en_wr,
   input  wire logic                                core_en_val,
   output logic                                     core_rd_val,
   output logic      [dio_pkg::CORE_N-1:0]          core_rd_all,
   input  wire logic [dio_pkg::TRIG_N-1:0]          trig_en,
   input  wire logic [dio_pkg::TRIG_N-1:0]          trig_pol,
   input  wire logic [dio_pkg::TRIG_N-1:0]          sync_en,
   input  wire logic [dio_pkg::TRIG_N-1:0]          sync_pol,
   input  wire logic                                sw_trigger,
   output logic                                     trigger_fire,
   input  wire logic                                sync_cond,
   input  wire logic [dio_pkg::SHUNT_N-1:0]         shunt_in,
   input  wire logic [dio_pkg::SHUNT_N-1:0]         shunt_fault,
   output logic      [dio_pkg::SHUNT_N-1:0]         shunt_sink,
   input  wire logic [dio_pkg::SHUNT_IDX_W-1:0]     shunt_idx,
   input  wire logic                                shunt_wr,
   input  wire logic                                shunt_wr_ground,
   output logic      [dio_pkg::SHUNT_N-1:0]         shunt_ground
);
   import dio_pkg::*;

   // every register of the block lives in this one struct
   typedef struct packed {
      logic [CORE_N-1:0]  c_s1;
      logic [CORE_N-1:0]  c_s2;
      logic [SHUNT_N-1:0] s_s1;
      logic [SHUNT_N-1:0] s_s2;
      logic [CORE_N-1:0]  out;
      logic [CORE_N-1:0]  oe;
      logic [SHUNT_N-1:0] drv;
      logic [SHUNT_N-1:0] trip;
      logic               rd;
      logic               fire;
      logic [CORE_N-1:0]  pin_oe;
      logic [CORE_N-1:0]  pin_out;
      logic [SHUNT_N-1:0] sink;
   } state_t;

   state_t            st_ff;
   state_t            nxt_st;
   logic              trig_hit;
   logic              sync_hit;
   logic [CORE_N-1:0] alloc;
   logic [CORE_N-1:0] func_out;
   logic [CORE_N-1:0] sel;

   // trigger pattern looks only at synchronised pin levels
   pattern_match #(
      .W     (TRIG_N)
   ) u_trig (
      .lines (st_ff.c_s2[TRIG_BASE +: TRIG_N]),
      .mask  (trig_en),
      .pol   (trig_pol),
      .hit   (trig_hit)
   );

   // sync outputs driven to their polarity while the sync condition holds
   assign sync_hit = sync_cond;

   // allocation, function outputs and index decode
   always_comb begin
      alloc = '0;
      alloc[TRIG_BASE +: TRIG_N] = trig_en;
      alloc[SYNC_BASE +: TRIG_N] = sync_en;
      func_out = '0;
      if (sync_hit) begin
         func_out[SYNC_BASE +: TRIG_N] = sync_pol;
      end else begin
         func_out[SYNC_BASE +: TRIG_N] = ~sync_pol;
      end
      sel = '0;
      if (core_idx >= CORE_IDX_FIRST && core_idx <= CORE_IDX_LAST) begin
         sel[3'(core_idx - CORE_IDX_FIRST)] = 1'b1;
      end
   end

   always_comb begin
      nxt_st = st_ff;

      // two-flop synchronisers for the pin levels
      nxt_st.c_s1 = core_discrete_in;
      nxt_st.c_s2 = st_ff.c_s1;
      nxt_st.s_s1 = shunt_in;
      nxt_st.s_s2 = st_ff.s_s1;

      // host writes to the core discretes
      for (int i = 0; i < CORE_N; i++) begin
         if (sel[i] && core_wr) begin
            nxt_st.out[i] = core_wr_val;
            nxt_st.oe[i]  = 1'b1;
         end
         if (sel[i] && core_en_wr) begin
            nxt_st.oe[i] = core_en_val;
         end
      end

      // allocated lines keep their written state but the pin follows the function
      for (int k = 0; k < CORE_N; k++) begin
         if (alloc[k]) begin
            nxt_st.pin_oe[k]  = (k >= int'(SYNC_BASE));
            nxt_st.pin_out[k] = func_out[k];
         end else begin
            nxt_st.pin_oe[k]  = nxt_st.oe[k];
            nxt_st.pin_out[k] = nxt_st.out[k];
         end
      end

      // readback of the selected line, zero when allocated or index bad
      nxt_st.rd = |(sel & st_ff.c_s2 & ~alloc);

      // trigger from pins or from software, both start the process
      nxt_st.fire = trig_hit | sw_trigger;

      for (int j = 0; j < SHUNT_N; j++) begin
         // fault trips the driver; a fresh write is needed after it clears
         if (shunt_fault[j]) begin
            nxt_st.trip[j] = 1'b1;
         end else if (shunt_wr && shunt_idx == 5'(j)) begin
            nxt_st.trip[j] = 1'b0;
         end
         if (shunt_wr && shunt_idx == 5'(j)) begin
            nxt_st.drv[j] = shunt_wr_ground;
         end
      end

      // live fault masks the sink at once, not a cycle late
      nxt_st.sink = nxt_st.drv & ~nxt_st.trip & ~shunt_fault;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '{c_s1:    '0,
                    c_s2:    '0,
                    s_s1:    '0,
                    s_s2:    '0,
                    out:     CORE_OUT_RST,
                    oe:      CORE_EN_RST,
                    drv:     SHUNT_DRV_RST,
                    trip:    '0,
                    rd:      1'b0,
                    fire:    TRIG_RST[0],
                    pin_oe:  CORE_EN_RST,
                    pin_out: CORE_OUT_RST,
                    sink:    SHUNT_DRV_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign core_discrete_out = st_ff.pin_out;
   assign core_discrete_oe  = st_ff.pin_oe;
   assign core_rd_val       = st_ff.rd;
   assign core_rd_all       = st_ff.c_s2;
   assign trigger_fire      = st_ff.fire;
   assign shunt_sink        = st_ff.sink;
   // low pin = ground state, high = open
   assign shunt_ground      = ~st_ff.s_s2;
endmodule : discrete_io_trigger_sync

// ### pattern_match.sv
module pattern_match
   import dio_pkg::*;
#(
   parameter int unsigned W = 3
) (
   input  wire logic [W-1:0] lines,
   input  wire logic [W-1:0] mask,
   input  wire logic [W-1:0] pol,
   output logic              hit
);
   // empty mask never fires
   assign hit = (|mask) && ((~(lines ^ pol) | ~mask) == {W{1'b1}});
endmodule : pattern_match

// ### testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import dio_pkg::*;
   logic core_clk, rst, core_wr, core_wr_val, core_en_wr, core_en_val, sw_trigger, sync_cond;
   logic shunt_wr, shunt_wr_ground, core_rd_val, trigger_fire, seen;
   logic [CORE_N-1:0] core_discrete_in, core_discrete_out, core_discrete_oe, core_rd_all, ext;
   logic [TRIG_N-1:0] trig_en, trig_pol, sync_en, sync_pol;
   logic [SHUNT_N-1:0] shunt_in, shunt_fault, shunt_sink, shunt_ground, load;
   logic [IDX_W-1:0] core_idx;
   logic [SHUNT_IDX_W-1:0] shunt_idx;
   int mismatches, checks;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
   $display("Error %0t %h %h", $time, a, b); end end
   discrete_io_trigger_sync discrete_io_trigger_sync_i (.*);
   dio_pins dio_pins_i (.out(core_discrete_out), .oe(core_discrete_oe), .ext(ext),
      .sink(shunt_sink), .load(load), .pin(core_discrete_in), .spin(shunt_in));
   initial begin core_clk = 0; forever #5 core_clk = ~core_clk; end
   task step(input int n); repeat (n) @(posedge core_clk); #1; endtask : step
   task test_done;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   task t_core;
      for (int i = 1; i <= 8; i++) begin
         core_idx = 4'(i); core_wr_val = i[0]; core_wr = 1; step(1); core_wr = 0;
         `CHK(core_discrete_oe[i-1], 1'b1)
         step(3); `CHK(core_rd_val, core_wr_val)
      end
      `CHK(core_rd_all, 8'h55)
      core_en_val = 0; core_en_wr = 1; step(1); core_en_wr = 0;
      step(3); `CHK(core_rd_val, 1'b1)
      `CHK(core_rd_all, 8'hd5)
      core_idx = 4'h9; core_wr = 1; step(1); core_wr = 0; `CHK(core_discrete_oe, 8'h7f)
   endtask : t_core
   task t_trig;
      trig_en = 3'h3; trig_pol = 3'h1; ext[1:0] = 2'h1; core_idx = 4'h1; seen = 0;
      repeat (6) begin step(1); seen |= trigger_fire; end
      `CHK(seen, 1'b1)
      if (seen !== 1'b1) test_done();
      `CHK(core_rd_val, 1'b0)
      trig_pol = 3'h3; step(5); `CHK(trigger_fire, 1'b0)
      sw_trigger = 1; step(1); sw_trigger = 0; `CHK(trigger_fire, 1'b1)
      trig_en = 3'h0; sync_en = 3'h3; sync_pol = 3'h2; sync_cond = 1; step(2);
      `CHK(core_discrete_out[5:4], 2'h2)
      sync_cond = 0; step(2); `CHK(core_discrete_out[5:4], 2'h1)
   endtask : t_trig
   task t_shunt;
      shunt_idx = 5'h01; shunt_wr_ground = 1; shunt_wr = 1; step(1); shunt_wr = 0;
      `CHK(shunt_sink, 16'h0002)
      load[6] = 1; step(4); `CHK(shunt_ground[7:0], 8'h42)
      shunt_fault[1] = 1; step(3); `CHK(shunt_sink[1], 1'b0)
      shunt_fault[1] = 0; step(3); `CHK(shunt_sink[1], 1'b0)
      shunt_wr = 1; step(1); shunt_wr = 0; `CHK(shunt_sink[1], 1'b1)
   endtask : t_shunt
   initial begin
      {rst, core_wr, core_wr_val, core_en_wr, core_en_val, sw_trigger, sync_cond} = 7'h40;
      {shunt_wr, shunt_wr_ground, trig_en, trig_pol, sync_en, sync_pol} = 14'h0000;
      ext = 8'haa; shunt_fault = 0; load = 0; core_idx = 0; shunt_idx = 0;
      step(10); rst = 0;
      `CHK(core_discrete_oe, 8'h00)
      `CHK(shunt_sink, 16'h0000)
      t_core(); t_trig(); t_shunt();
      test_done();
   end
endmodule : testbench
bind discrete_io_trigger_sync dio_monitor dio_monitor_i (.*);
